// file: src/uarim_regs.sv
`timescale 1ns/1ps
// Contract
// - Three address bits select data, enable, status, line, modem, lstat, mstat, scratch.
// - Enable register masks four sources; unmasked pending ones raise irq, and the held one of them appears in status.
// - Enable bit 0 raises receive interrupt while a character is held; resets 0.
// - Enable bit 1 raises transmit interrupt once holding goes empty, or immediately on set while holding empty.
// - Enable bit 2 raises line status interrupt on line status bits 1 to 4.
// - Enable bit 3 gates modem status interrupt; defaults off.
// - Enable bit 5 turns special mode on, making modem bits 2 and 7 effective.
// - Status read returns the held code, picked highest first only once the held one clears; others stay pending.
// - A reported code is not replaced until its clearing action happens.
// - Line control bit 7 swaps addresses 0 and 1 to divisor low and high.
// - Status bits 3:1 code line 011, receive 010, transmit 001, modem 000.
// - Status bit 0 reads 0 when pending, 1 when idle and at reset.
// - Receive read clears receive irq; data write or status read plus disable clears tx.
module uarim_regs
	import uarim_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire uarim_bus_t bus_i,
	output logic [7:0] rdata_q,
	input wire logic [7:0] rx_data,
	input wire logic rx_ready,
	input wire logic tx_hold_empty,
	input wire logic [7:0] line_status,
	input wire logic [7:0] modem_status,
	output logic [7:0] tx_data_q,
	output logic tx_load_q,
	output logic rx_unload_q,
	output logic lstat_read_q,
	output logic mstat_read_q,
	output logic [7:0] line_control_q,
	output logic [7:0] modem_control_q,
	output logic [15:0] divisor_q,
	output logic soft_reset_q,
	output logic power_down_q,
	output logic irq_q
);
	// ========================================
	// Pin synchronisers for status from the serial side
	// Receive byte takes the same two stages as its ready flag, so both arrive together
	logic [7:0] lstat_s1_q, lstat_s2_q, mstat_s1_q, mstat_s2_q, rxd_s1_q, rxd_s2_q;
	logic [1:0] rdy_s1_q, rdy_s2_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lstat_s1_q <= 8'h00;
			lstat_s2_q <= 8'h00;
			mstat_s1_q <= 8'h00;
			mstat_s2_q <= 8'h00;
			rxd_s1_q <= 8'h00;
			rxd_s2_q <= 8'h00;
			rdy_s1_q <= 2'h0;
			rdy_s2_q <= 2'h0;
		end else begin
			lstat_s1_q <= line_status;
			lstat_s2_q <= lstat_s1_q;
			mstat_s1_q <= modem_status;
			mstat_s2_q <= mstat_s1_q;
			rxd_s1_q <= rx_data;
			rxd_s2_q <= rxd_s1_q;
			rdy_s1_q <= {tx_hold_empty, rx_ready};
			rdy_s2_q <= rdy_s1_q;
		end
	end

	// ========================================
	// Address decode
	logic [7:0] ien_q, scr_q, div_lo_q, div_hi_q;
	logic dlab, rd_data, wr_data, rd_ien, wr_ien, rd_isrc;
	assign dlab = line_control_q[UARIM_LCTL_DLAB];
	function automatic logic hit(input logic [2:0] a, input logic [2:0] o, input logic s);
		hit = s && (a == o);
	endfunction
	assign rd_data = hit(bus_i.addr, UARIM_OFS_DATA, bus_i.rd) && !dlab;
	assign wr_data = hit(bus_i.addr, UARIM_OFS_DATA, bus_i.wr) && !dlab;
	assign rd_ien = hit(bus_i.addr, UARIM_OFS_IEN, bus_i.rd) && !dlab;
	assign wr_ien = hit(bus_i.addr, UARIM_OFS_IEN, bus_i.wr) && !dlab;
	assign rd_isrc = hit(bus_i.addr, UARIM_OFS_ISRC, bus_i.rd);

	// ========================================
	// Writable registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ien_q <= UARIM_RST_REG;
			line_control_q <= UARIM_RST_REG;
			modem_control_q <= UARIM_RST_REG;
			scr_q <= UARIM_RST_REG;
			div_lo_q <= UARIM_RST_DIV;
			div_hi_q <= UARIM_RST_REG;
			tx_data_q <= UARIM_RST_REG;
		end else if (bus_i.wr) begin
			unique case (bus_i.addr)
				UARIM_OFS_DATA: begin
					if (dlab) begin
						div_lo_q <= bus_i.wdata;
					end else begin
						tx_data_q <= bus_i.wdata;
					end
				end
				UARIM_OFS_IEN: begin
					if (dlab) begin
						div_hi_q <= bus_i.wdata;
					end else begin
						ien_q <= bus_i.wdata & UARIM_IEN_MASK;
					end
				end
				UARIM_OFS_LCTL: line_control_q <= bus_i.wdata;
				UARIM_OFS_MCTL: modem_control_q <= bus_i.wdata;
				UARIM_OFS_SCR: scr_q <= bus_i.wdata;
				default: ;
			endcase
		end
	end
	assign divisor_q = {div_hi_q, div_lo_q};

	// ========================================
	// Access strobes to the serial side
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_load_q <= 1'b0;
			rx_unload_q <= 1'b0;
			lstat_read_q <= 1'b0;
			mstat_read_q <= 1'b0;
		end else begin
			tx_load_q <= wr_data;
			rx_unload_q <= rd_data;
			lstat_read_q <= hit(bus_i.addr, UARIM_OFS_LSTAT, bus_i.rd);
			mstat_read_q <= hit(bus_i.addr, UARIM_OFS_MSTAT, bus_i.rd);
		end
	end

	// Special functions only take effect in special mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			soft_reset_q <= 1'b0;
			power_down_q <= 1'b0;
		end else begin
			soft_reset_q <= ien_q[UARIM_IEN_SPC] && modem_control_q[UARIM_MCTL_SRST];
			power_down_q <= ien_q[UARIM_IEN_SPC] && modem_control_q[UARIM_MCTL_PDN];
		end
	end

	// ========================================
	// Interrupt sources
	logic tx_pend_q, tx_seen_q, isrc_read_q;
	logic ls_act, rx_act, tx_act, ms_act;
	assign ls_act = ien_q[UARIM_IEN_LS] && |(lstat_s2_q & UARIM_LSTAT_ERR);
	assign rx_act = ien_q[UARIM_IEN_RX] && rdy_s2_q[0];
	assign ms_act = ien_q[UARIM_IEN_MS] && |(mstat_s2_q & UARIM_MSTAT_DELTA);
	assign tx_act = ien_q[UARIM_IEN_TX] && tx_pend_q;

	// Transmit-ready is latched so that it survives until an explicit clear, not
	// just until the empty flag toggles; set has priority over clear.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_pend_q <= 1'b0;
			tx_seen_q <= 1'b0;
			isrc_read_q <= 1'b0;
		end else begin
			tx_seen_q <= rdy_s2_q[1];
			if (rd_isrc) begin
				isrc_read_q <= 1'b1;
			end else if (wr_ien) begin
				isrc_read_q <= 1'b0;
			end
			if ((rdy_s2_q[1] && !tx_seen_q) ||
				(wr_ien && bus_i.wdata[UARIM_IEN_TX] && !ien_q[UARIM_IEN_TX] &&
				rdy_s2_q[1])) begin
				tx_pend_q <= 1'b1;
			end else if (wr_data ||
				(wr_ien && isrc_read_q && !bus_i.wdata[UARIM_IEN_TX])) begin
				tx_pend_q <= 1'b0;
			end
		end
	end

	// ========================================
	// Priority and held report
	uarim_src_t cur_q, best;
	always_comb begin
		best = UARIM_SRC_NONE;
		if (ls_act) begin
			best = UARIM_SRC_LS;
		end else if (rx_act) begin
			best = UARIM_SRC_RX;
		end else if (tx_act) begin
			best = UARIM_SRC_TX;
		end else if (ms_act) begin
			best = UARIM_SRC_MS;
		end
	end

	function automatic logic still(input uarim_src_t s, input logic l, input logic r,
		input logic t, input logic m);
		unique case (s)
			UARIM_SRC_LS: still = l;
			UARIM_SRC_RX: still = r;
			UARIM_SRC_TX: still = t;
			UARIM_SRC_MS: still = m;
			default: still = 1'b0;
		endcase
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_q <= UARIM_SRC_NONE;
		end else if (!still(cur_q, ls_act, rx_act, tx_act, ms_act) && !rd_isrc) begin
			cur_q <= best;
		end
	end

	function automatic logic [3:0] code_of(input uarim_src_t s);
		unique case (s)
			UARIM_SRC_LS: code_of = UARIM_CODE_LS;
			UARIM_SRC_RX: code_of = UARIM_CODE_RX;
			UARIM_SRC_TX: code_of = UARIM_CODE_TX;
			UARIM_SRC_MS: code_of = UARIM_CODE_MS;
			default: code_of = UARIM_CODE_NONE;
		endcase
	endfunction

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= ls_act || rx_act || tx_act || ms_act;
		end
	end

	// ========================================
	// Read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (bus_i.rd) begin
			unique case (bus_i.addr)
				UARIM_OFS_DATA: rdata_q <= dlab ? div_lo_q : rxd_s2_q;
				UARIM_OFS_IEN: rdata_q <= dlab ? div_hi_q : ien_q;
				UARIM_OFS_ISRC: rdata_q <= {4'h0, code_of(cur_q)};
				UARIM_OFS_LCTL: rdata_q <= line_control_q;
				UARIM_OFS_MCTL: rdata_q <= modem_control_q;
				UARIM_OFS_LSTAT: rdata_q <= lstat_s2_q;
				UARIM_OFS_MSTAT: rdata_q <= mstat_s2_q;
				UARIM_OFS_SCR: rdata_q <= scr_q;
				default: rdata_q <= 8'h00;
			endcase
		end
	end
endmodule

// file: src/uarim_pkg.sv
package uarim_pkg;
	// ========================================
	// Register offsets
	localparam logic [2:0] UARIM_OFS_DATA = 3'h0;
	localparam logic [2:0] UARIM_OFS_IEN = 3'h1;
	localparam logic [2:0] UARIM_OFS_ISRC = 3'h2;
	localparam logic [2:0] UARIM_OFS_LCTL = 3'h3;
	localparam logic [2:0] UARIM_OFS_MCTL = 3'h4;
	localparam logic [2:0] UARIM_OFS_LSTAT = 3'h5;
	localparam logic [2:0] UARIM_OFS_MSTAT = 3'h6;
	localparam logic [2:0] UARIM_OFS_SCR = 3'h7;
	// ========================================
	// Field positions
	localparam int UARIM_IEN_RX = 0;
	localparam int UARIM_IEN_TX = 1;
	localparam int UARIM_IEN_LS = 2;
	localparam int UARIM_IEN_MS = 3;
	localparam int UARIM_IEN_SPC = 5;
	localparam int UARIM_LCTL_DLAB = 7;
	localparam int UARIM_MCTL_SRST = 2;
	localparam int UARIM_MCTL_PDN = 7;
	localparam logic [7:0] UARIM_IEN_MASK = 8'h2F;
	localparam logic [7:0] UARIM_LSTAT_ERR = 8'h1E;
	localparam logic [7:0] UARIM_MSTAT_DELTA = 8'h0F;
	// ========================================
	// Reset values
	localparam logic [7:0] UARIM_RST_REG = 8'h00;
	localparam logic [7:0] UARIM_RST_DIV = 8'h01;
	// ========================================
	// Interrupt source codes, bits 3:0 of the status read
	localparam logic [3:0] UARIM_CODE_NONE = 4'h1;
	localparam logic [3:0] UARIM_CODE_LS = 4'h6;
	localparam logic [3:0] UARIM_CODE_RX = 4'h4;
	localparam logic [3:0] UARIM_CODE_TX = 4'h2;
	localparam logic [3:0] UARIM_CODE_MS = 4'h0;

	typedef enum logic [2:0] {
		UARIM_SRC_NONE,
		UARIM_SRC_LS,
		UARIM_SRC_RX,
		UARIM_SRC_TX,
		UARIM_SRC_MS
	} uarim_src_t;

	typedef struct packed {
		logic [2:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} uarim_bus_t;
endpackage

// file: tb/uarim_host.sv
`timescale 1ns/1ps
// ========================================
// Host model: one strobe per access, then one idle cycle
module uarim_host
	import uarim_pkg::*;
(
	input wire logic clk,
	output uarim_bus_t bus_o
);
	initial bus_o = '0;
	task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_o <= '{addr: a, rd: r, wr: !r, wdata: d};
		@(posedge clk);
		bus_o <= '0; // Drop strobe so one access is never taken twice
	endtask
endmodule

// file: tb/uarim_regs_chk.sv
`timescale 1ns/1ps
// ========================================
// Port checker
module uarim_regs_chk
	import uarim_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire uarim_bus_t bus_i,
	input wire logic [7:0] rdata_q,
	input wire logic [7:0] tx_data_q,
	input wire logic tx_load_q,
	input wire logic rx_unload_q,
	input wire logic lstat_read_q,
	input wire logic [7:0] line_control_q,
	input wire logic [7:0] modem_control_q,
	input wire logic [15:0] divisor_q,
	input wire logic soft_reset_q,
	input wire logic power_down_q,
	input wire logic irq_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic src_rd;
	logic d0;
	logic spc_q;
	assign src_rd = bus_i.rd && bus_i.addr == 3'h2;
	assign d0 = bus_i.addr == 3'h0 && !line_control_q[7];
	// Special mode bit is not a port, so it is rebuilt from host writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spc_q <= 1'b0;
		end else if (bus_i.wr && bus_i.addr == 3'h1 && !line_control_q[7]) begin
			spc_q <= bus_i.wdata[5];
		end
	end
	property p_src_rsv; src_rd |=> rdata_q[7:4] == 4'h0; endproperty
	a_src_rsv: assert property (p_src_rsv) else $error("status high nibble set");
	property p_code; src_rd |=> rdata_q[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6}; endproperty
	a_code: assert property (p_code) else $error("bad source code");
	property p_tx; bus_i.wr && d0 |=> tx_load_q && tx_data_q == $past(bus_i.wdata); endproperty
	a_tx: assert property (p_tx) else $error("data write not loaded");
	property p_rx; bus_i.rd && d0 |=> rx_unload_q; endproperty
	a_rx: assert property (p_rx) else $error("data read not unloaded");
	property p_div;
		bus_i.wr && bus_i.addr == 3'h0 && line_control_q[7]
			|=> divisor_q[7:0] == $past(bus_i.wdata) && !tx_load_q;
	endproperty
	a_div: assert property (p_div) else $error("divisor low write wrong");
	property p_dvh;
		bus_i.wr && bus_i.addr == 3'h1 && line_control_q[7]
			|=> divisor_q[15:8] == $past(bus_i.wdata);
	endproperty
	a_dvh: assert property (p_dvh) else $error("divisor high write wrong");
	property p_lc;
		bus_i.wr && bus_i.addr == 3'h3
			|=> line_control_q == $past(bus_i.wdata);
	endproperty
	a_lc: assert property (p_lc) else $error("line control write wrong");
	property p_lsr; bus_i.rd && bus_i.addr == 3'h5 |=> lstat_read_q; endproperty
	a_lsr: assert property (p_lsr) else $error("line status read missed");
	property p_srst;
		soft_reset_q == ($past(spc_q) && $past(modem_control_q[2]));
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset without modem bit");
	property p_pdn;
		power_down_q == ($past(spc_q) && $past(modem_control_q[7]));
	endproperty
	a_pdn: assert property (p_pdn) else $error("power down without modem bit");
	property p_hold; !bus_i.rd |=> $stable(rdata_q); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	c_tx: cover property (tx_load_q);
	c_irq: cover property ($rose(irq_q));
	c_srst: cover property (soft_reset_q);
endmodule

// file: tb/uarim_regs_tb_top.sv
`timescale 1ns/1ps
// ========================================
// Testbench: reads queue {irq, data} notes, checker pops them
module uarim_regs_tb_top import uarim_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	uarim_bus_t bus;
	logic [7:0] rdata_q, rx_data = 8'h00, line_status = 8'h00, modem_status = 8'h00;
	logic rx_ready = 1'b0, tx_hold_empty = 1'b1;
	logic tx_load_q, rx_unload_q, lstat_read_q, mstat_read_q, irq_q, pend = 1'b0;
	logic [31:0] lfsr = 32'h00010F6E;
	logic [8:0] exp_q[$];
	logic [8:0] e;
	logic [7:0] v, r;
	int err_total = 0, n_tests = 0, cyc = 0;
	initial forever #12.5 clk = ~clk;
	uarim_host uarim_host_i(.clk(clk), .bus_o(bus));
	uarim_regs uarim_regs_i(.clk(clk), .rst(rst), .bus_i(bus), .rdata_q(rdata_q),
		.rx_data(rx_data), .rx_ready(rx_ready), .tx_hold_empty(tx_hold_empty),
		.line_status(line_status), .modem_status(modem_status), .tx_data_q(),
		.tx_load_q(tx_load_q), .rx_unload_q(rx_unload_q), .lstat_read_q(lstat_read_q),
		.mstat_read_q(mstat_read_q), .line_control_q(), .modem_control_q(),
		.divisor_q(), .soft_reset_q(), .power_down_q(), .irq_q(irq_q));
	task automatic summarize();
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		uarim_host_i.acc(1'b0, a, d);
	endtask
	task automatic rd(input logic [2:0] a, input logic [8:0] x);
		exp_q.push_back(x);
		uarim_host_i.acc(1'b1, a, 8'h00);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		v = lfsr[7:0];
	endtask
	// Serial side drops its levels once the host has serviced them
	always @(posedge clk) begin
		if (rx_unload_q) rx_ready <= 1'b0;
		if (lstat_read_q) line_status <= 8'h00;
		if (mstat_read_q) modem_status <= 8'h00;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		pend <= bus.rd;
		if (pend) begin
			e = exp_q.pop_front();
			n_tests++;
			if ({irq_q, rdata_q} !== e) begin
				err_total++;
				$display("unexpected at %0t: got %h want %h", $time, {irq_q, rdata_q}, e);
			end
		end
		if (cyc == 3000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		idle(12);
		rst <= 1'b0;
		idle(3);
		rd(3'h2, 9'h001);
		rd(3'h1, 9'h000);
		for (int i = 0; i < 4; i++) begin
			rnd();
			wr(3'h7, v);
			rd(3'h7, {1'b0, v});
		end
		wr(3'h1, 8'hFF);
		rd(3'h1, 9'h12F);
		rd(3'h2, 9'h102);
		rnd();
		r = v;
		rx_data <= r;
		rx_ready <= 1'b1;
		idle(4);
		rd(3'h2, 9'h102);
		rnd();
		wr(3'h0, v);
		idle(2);
		rd(3'h2, 9'h104);
		line_status <= 8'h22;
		idle(4);
		rd(3'h2, 9'h104);
		rd(3'h0, {1'b1, r});
		idle(4);
		rd(3'h2, 9'h106);
		rd(3'h5, 9'h122);
		idle(4);
		modem_status <= 8'h01;
		idle(4);
		rd(3'h2, 9'h100);
		rd(3'h6, 9'h101);
		idle(4);
		rd(3'h2, 9'h001);
		wr(3'h3, 8'h80);
		rnd();
		r = v;
		wr(3'h0, r);
		rnd();
		wr(3'h1, v);
		rd(3'h0, {1'b0, r});
		rd(3'h1, {1'b0, v});
		wr(3'h3, 8'h03);
		rd(3'h3, 9'h003);
		rd(3'h1, 9'h02F);
		wr(3'h1, 8'h00);
		wr(3'h4, 8'h84);
		wr(3'h1, 8'h02);
		rd(3'h2, 9'h102);
		wr(3'h1, 8'h20);
		idle(2);
		rd(3'h2, 9'h001);
		wr(3'h4, 8'h84);
		rd(3'h4, 9'h084);
		idle(4);
		summarize();
	end
endmodule
bind uarim_regs uarim_regs_chk uarim_regs_chk_i(.clk(clk), .rst(rst), .bus_i(bus_i),
	.rdata_q(rdata_q), .tx_data_q(tx_data_q), .tx_load_q(tx_load_q),
	.rx_unload_q(rx_unload_q), .lstat_read_q(lstat_read_q),
	.line_control_q(line_control_q), .modem_control_q(modem_control_q),
	.divisor_q(divisor_q), .soft_reset_q(soft_reset_q), .power_down_q(power_down_q),
	.irq_q(irq_q));
